// ---- hw/sram_host_pkg.sv ----
// Package: constants and carrier types for the async SRAM host port
package sram_host_pkg;

  // ==========================================================
  // Geometry
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;

  // ==========================================================
  // Timing figures in ns, as printed
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_TO_VALID_DELAY_NS = 25;  // Read access, max
  localparam int DRIVE_TO_VALID_DELAY_NS = 12; // Enable to data, max
  localparam int DRIVE_RELEASE_DELAY_NS = 12;  // Enable high to float
  localparam int WRITE_CYCLE_NS = 25;          // Least write cycle
  localparam int SELECT_TO_WRITE_END_NS = 20;
  localparam int ADDR_SETUP_TO_WRITE_END_NS = 20;
  localparam int WRITE_STROBE_WIDTH_NS = 12;
  localparam int WDATA_SETUP_NS = 10;
  localparam int ADDR_HOLD_AFTER_WRITE_NS = 2;

  // Least times round up to whole cycles, never below one
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Read wait covers access plus one sample slot
  localparam int READ_WAIT_CYC =
    min_cycles(ADDR_TO_VALID_DELAY_NS) + 1;
  // Strobe low long enough for width, setup and cycle length
  localparam int STROBE_CYC = min_cycles(WRITE_CYCLE_NS);
  localparam int WDATA_SETUP_CYC = min_cycles(WDATA_SETUP_NS);
  localparam int ADDR_HOLD_CYC = min_cycles(ADDR_HOLD_AFTER_WRITE_NS);
  localparam int RELEASE_CYC = min_cycles(DRIVE_RELEASE_DELAY_NS);
  localparam int CNT_W = 4;

  // ==========================================================
  // Pin bundles
  typedef struct packed {
    logic [ADDR_W-1:0] word_select_lines;
    logic chip_select_n;
    logic write_strobe_n;
    logic output_enable_n;
  } sram_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_RREL = 3'b010,
    ST_WSET = 3'b011,
    ST_WSTB = 3'b100,
    ST_WHLD = 3'b101
  } state_t;

endpackage

// ---- hw/sram_host.sv ----
// Host-side controller driving a 2048x8 asynchronous static RAM
`timescale 1ns/1ps
module sram_host (
  input wire logic sys_clk,  // 100 MHz clock
  input wire logic resetn,   // Async reset, active low
  // User request side
  input wire logic req_valid,  // Request present
  output logic req_ready,      // Request taken this cycle
  input wire logic req_write,  // 1 write, 0 read
  input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr,  // Word address
  input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata, // Write data
  output logic rsp_valid,      // Read data pulse
  output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata,  // Read data
  // Memory pins
  output sram_host_pkg::sram_ctrl_t mem_ctrl,  // Address and strobes
  input wire logic [sram_host_pkg::DATA_W-1:0] shared_data_bus_in,  // Pins
  output logic [sram_host_pkg::DATA_W-1:0] shared_data_bus_out,  // Drive
  output logic shared_data_bus_oe  // High while host drives
);

  // ==========================================================
  // State
  sram_host_pkg::state_t state_reg;
  logic [sram_host_pkg::CNT_W-1:0] cnt_reg;
  logic write_reg;
  logic [sram_host_pkg::DATA_W-1:0] sync1_reg, sync2_reg, sync3_reg;
  // Pin flops, gathered into the output bundle further down
  logic [sram_host_pkg::ADDR_W-1:0] addr_reg;  // Address pins
  logic cs_n_reg;  // Select pin
  logic we_n_reg;  // Write strobe pin
  logic oe_n_reg;  // Output enable pin
  logic read_end;  // Last release cycle of a read

  // Handshake is combinational: accept only in idle
  assign req_ready = (state_reg == sram_host_pkg::ST_IDLE);

  // Count compare value at counter width
  function automatic logic [sram_host_pkg::CNT_W-1:0] cyc(input int n);
    return sram_host_pkg::CNT_W'(n);
  endfunction

  // Strobe phase: every strobe count but the last, so select and
  // strobe rise together on one edge
  function automatic logic in_strobe(
    input sram_host_pkg::state_t st,
    input logic [sram_host_pkg::CNT_W-1:0] cnt
  );
    return st == sram_host_pkg::ST_WSTB &&
           cnt != cyc(sram_host_pkg::STROBE_CYC - 1);
  endfunction

  // Read ends as the release wait closes; the device let go of the
  // bus one cycle earlier
  assign read_end = state_reg == sram_host_pkg::ST_RREL &&
                    cnt_reg == cyc(sram_host_pkg::RELEASE_CYC - 1);

  // ==========================================================
  // Sequencer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= sram_host_pkg::ST_IDLE;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        sram_host_pkg::ST_IDLE: begin
          if (req_valid) begin
            cnt_reg <= '0;
            state_reg <= req_write ? sram_host_pkg::ST_WSET
                                   : sram_host_pkg::ST_READ;
          end
        end
        sram_host_pkg::ST_READ: begin
          if (cnt_reg == cyc(sram_host_pkg::READ_WAIT_CYC - 1)) begin
            cnt_reg <= '0;
            state_reg <= sram_host_pkg::ST_RREL;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        sram_host_pkg::ST_RREL: begin
          if (cnt_reg == cyc(sram_host_pkg::RELEASE_CYC - 1)) begin
            state_reg <= sram_host_pkg::ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        sram_host_pkg::ST_WSET: begin
          cnt_reg <= '0;
          state_reg <= sram_host_pkg::ST_WSTB;
        end
        sram_host_pkg::ST_WSTB: begin
          if (cnt_reg == cyc(sram_host_pkg::STROBE_CYC - 1)) begin
            cnt_reg <= '0;
            state_reg <= sram_host_pkg::ST_WHLD;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        sram_host_pkg::ST_WHLD: begin
          if (cnt_reg == cyc(sram_host_pkg::ADDR_HOLD_CYC - 1)) begin
            state_reg <= sram_host_pkg::ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= sram_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Pin drive: address and data latched at acceptance
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr_reg <= '0;
      shared_data_bus_out <= '0;
      write_reg <= 1'b0;
    end else if (req_ready && req_valid) begin
      // address moves with select, never after
      addr_reg <= req_addr;
      shared_data_bus_out <= req_wdata;
      write_reg <= req_write;
    end
  end

  // Strobes from flip-flops, glitch free
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cs_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      shared_data_bus_oe <= 1'b0;
    end else begin
      // select only during a cycle, standby otherwise
      cs_n_reg <= !(
        (state_reg == sram_host_pkg::ST_IDLE && req_valid) ||
        state_reg == sram_host_pkg::ST_READ ||
        state_reg == sram_host_pkg::ST_WSET ||
        in_strobe(state_reg, cnt_reg));
      // strobe low only in write strobe phase
      we_n_reg <= !(state_reg == sram_host_pkg::ST_WSET ||
                    in_strobe(state_reg, cnt_reg));
      // outputs enabled through the whole access wait, so the
      // last two synchroniser samples both lie after the access time
      oe_n_reg <= !(
        (state_reg == sram_host_pkg::ST_IDLE && req_valid &&
         !req_write) ||
        state_reg == sram_host_pkg::ST_READ);
      // data driven from select through hold, held past end
      shared_data_bus_oe <= (state_reg == sram_host_pkg::ST_IDLE &&
                             req_valid && req_write) ||
                            state_reg == sram_host_pkg::ST_WSET ||
                            state_reg == sram_host_pkg::ST_WSTB;
    end
  end

  // Pins leave as one bundle; every field comes straight from a flop,
  // so the strobes cannot glitch between edges
  assign mem_ctrl = '{
    word_select_lines: addr_reg,
    chip_select_n: cs_n_reg,
    write_strobe_n: we_n_reg,
    output_enable_n: oe_n_reg
  };

  // ==========================================================
  // Read data passes three flops; stage three taken when stages agree, else stage two
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= shared_data_bus_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Capture once the read's release wait ends
  // Select and enable rose one cycle ago; stages two and three then
  // hold pin levels from the two enabled edges before the last
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      // both stages now hold levels taken after access time
      if (read_end && !write_reg && sync2_reg == sync3_reg) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= sync3_reg;
      end else if (read_end) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= sync2_reg;
      end
    end
  end

endmodule // sram_host

// ---- dv/sram_host_assertions.sv ----
// Checker for the host pin timing of the SRAM port
`timescale 1ns/1ps
module sram_host_assertions (
  input wire logic sys_clk,  // Clock
  input wire logic resetn,  // Reset, active low
  input wire logic rsp_valid,  // Read pulse
  input wire sram_host_pkg::sram_ctrl_t mem_ctrl,  // Pins
  input wire logic [7:0] shared_data_bus_out,  // Host drive
  input wire logic shared_data_bus_oe  // Host enable
);
  wire cs_n = mem_ctrl.chip_select_n;
  wire we_n = mem_ctrl.write_strobe_n;
  wire oe_n = mem_ctrl.output_enable_n;
  wire [10:0] adr = mem_ctrl.word_select_lines;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Pin order
  strobe_in_read_a: assert property (!oe_n |-> we_n)
    else $error("strobe low while reading");
  no_collide_a: assert property (!oe_n |-> !shared_data_bus_oe)
    else $error("host drives while device enabled");
  strobe_in_cs_a: assert property (!we_n |-> !cs_n)
    else $error("strobe low without select");
  cs_before_we_a: assert property ($fell(we_n) |-> $past(!cs_n))
    else $error("select not ahead of strobe");
  strobe_width_a: assert property ($fell(we_n) |->
    (!we_n)[*3] ##1 (we_n && cs_n))
    else $error("strobe width or end wrong");
  wdata_hold_a: assert property ($fell(we_n) |->
    ($stable(shared_data_bus_out) && shared_data_bus_oe)[*4])
    else $error("write data not held");
  addr_steady_a: assert property (!cs_n && $past(!cs_n) |-> $stable(adr))
    else $error("address moved while selected");
  addr_hold_a: assert property ($rose(we_n) |=> $stable(adr))
    else $error("address not held after write");
  read_answer_a: assert property ($fell(oe_n) |-> ##6 rsp_valid)
    else $error("read answer late");
  release_gap_a: assert property ($rose(oe_n) |->
    (!shared_data_bus_oe)[*2])
    else $error("host drives before device release");
endmodule // sram_host_assertions
bind sram_host sram_host_assertions chk_i (.sys_clk(sys_clk), .resetn(resetn),
  .rsp_valid(rsp_valid), .mem_ctrl(mem_ctrl),
  .shared_data_bus_out(shared_data_bus_out),
  .shared_data_bus_oe(shared_data_bus_oe));

// ---- dv/sram_dev_model.sv ----
// Behavioural model of the 2048x8 asynchronous static RAM
`timescale 1ns/1ps
module sram_dev_model (
  input wire sram_host_pkg::sram_ctrl_t ctrl,  // Host pins
  input wire logic [7:0] din,  // Resolved bus level
  output logic [7:0] q  // Device drive, junk when floating
);
  logic [7:0] mem [2048];
  logic [7:0] last;
  logic [11:0] late;
  wire [10:0] a = ctrl.word_select_lines;
  wire rd = !ctrl.chip_select_n && !ctrl.output_enable_n && ctrl.write_strobe_n;
  always @(ctrl or din) begin
    if (!ctrl.chip_select_n && !ctrl.write_strobe_n) mem[a] = din;
  end
  assign #25 late = {rd, a};
  always @* begin
    if (rd && late == {rd, a}) last = mem[a];
    q = (rd && late == {rd, a}) ? last : ~last;
  end
endmodule // sram_dev_model

// ---- dv/sram_host_tb.sv ----
// Self-checking testbench for the SRAM host port
`timescale 1ns/1ps
module sram_host_tb;
  logic sys_clk = 0, resetn = 0, req_valid = 0, req_write = 0;
  logic req_ready, rsp_valid, shared_data_bus_oe;
  logic [10:0] req_addr = '0;
  logic [7:0] req_wdata = '0, rsp_rdata, shared_data_bus_out, dev_q, bus;
  sram_host_pkg::sram_ctrl_t mem_ctrl;
  logic [7:0] shadow [2048];
  logic [7:0] expq [$];
  logic [10:0] adrs [18];
  int fails = 0, compares = 0;
  assign bus = shared_data_bus_oe ? shared_data_bus_out : dev_q;
  sram_host uut (.sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_ctrl(mem_ctrl), .shared_data_bus_in(bus),
    .shared_data_bus_out(shared_data_bus_out),
    .shared_data_bus_oe(shared_data_bus_oe));
  sram_dev_model dev (.ctrl(mem_ctrl), .din(bus), .q(dev_q));
  // ==========================================================
  // Clock, checks and closing
  initial forever #5 sys_clk = ~sys_clk;
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Request with bounded wait for acceptance
  task req(input logic w, input logic [10:0] a, input logic [7:0] d);
    int n;
    @(negedge sys_clk);
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (req_ready === 1'b1) break;
    end
    if (n == 20) chk("req_ready", 8'h01, 8'h00);
    if (w) shadow[a] = d;
    else expq.push_back(shadow[a]);
  endtask
  // Read results against the oldest note, looked at mid-cycle
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      if (expq.size() == 0) chk("extra rsp", 8'h00, 8'h01);
      else chk("rsp_rdata", expq.pop_front(), rsp_rdata);
    end
  end
  initial begin
    #50000;
    fails++;
    complete_run;
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h1796));
    repeat (12) @(negedge sys_clk);
    resetn = 1;
    adrs[0] = 11'h000;
    adrs[1] = 11'h7FF;
    for (int i = 2; i < 18; i++) adrs[i] = 11'($urandom);
    // Boundaries and random places, repeats not excluded
    foreach (adrs[i]) req(1'b1, adrs[i], 8'($urandom));
    foreach (adrs[i]) req(1'b0, adrs[i], 8'h00);
    // Overwrite then read back to back
    foreach (adrs[i]) begin
      req(1'b1, adrs[i], ~shadow[adrs[i]]);
      req(1'b0, adrs[i], 8'h00);
    end
    @(negedge sys_clk);
    req_valid = 0;
    repeat (12) @(negedge sys_clk);
    chk("pending", 8'h00, 8'(expq.size()));
    complete_run;
  end
endmodule // sram_host_tb
